// ===== hw/coin_credit_pkg.sv
// Constants shared by the coin credit and play control block
// Operation
// - Coin switch caught in debounce flag
// - Wait 10 ms before coin accepted
// - Debounce flag inhibits start, starts timer
// - Coin pulse clears expired flag, loads games flag from setting
// - Held credit enables start, lights indicator
// - Switch release resets flag, clears trigger
// - Power-up: latch off, attract, no start
// - Coin pulse sets self-holding credit latch
// - Static detect clears latch, overrides coin
// - Expired credit in attract clears latch
// - One game: game over expires credit
// - Two games: first game over only marks
// - Two games: second game over expires credit
// - Attract clears on start, sets on stop
`default_nettype none
package coin_credit_pkg;
   // System clock rate in hertz
   localparam int unsigned CLK_HZ        = 20_000_000;
   // Coin qualification delay in milliseconds
   localparam int unsigned QUAL_DELAY_MS = 10;
   // Delay in clock cycles, rounded down
   localparam int unsigned QUAL_CYCLES   =
      (CLK_HZ / 1000) * QUAL_DELAY_MS;
   // Width of the qualification counter
   localparam int unsigned QUAL_W        = 18;
   // Reset values of the flags
   localparam logic CREDIT_RST   = 1'b0;
   localparam logic EXPIRED_RST  = 1'b1;
   localparam logic ATTRACT_RST  = 1'b1;
   localparam logic GAMES_RST    = 1'b1;
endpackage : coin_credit_pkg
`default_nettype wire

// ===== hw/coin_sync.sv
// Two-stage synchroniser for one asynchronous input
`default_nettype none
module coin_sync
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // Data
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_reg;   // First stage, read only by second

   // Two flops; reset level chosen as the idle value
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         meta_reg <= 1'b0;
         sync_o   <= 1'b0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule : coin_sync
`default_nettype wire

// ===== hw/coin_credit_play_control.sv
// Coin credit, electronic latch and attract control
`default_nettype none
module coin_credit_play_control
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // Cabinet inputs, asynchronous
   input  wire logic coin_sw_n_i,            // Low while coin passes
   input  wire logic static_detect_i,        // High on static charge
   input  wire logic games_per_coin_select_i,// 1: two, 0: one
   // Game logic, same clock
   input  wire logic start_accept_i,         // Start pressed, pulse
   input  wire logic game_stop_i,            // Game over, level
   // Outputs to start and game logic
   output logic      coin_accepted_n_o,      // Accept pulse, low
   output logic      start_inhibit_o,        // Coin in progress
   output logic      start_enable_o,         // Credit present
   output logic      credit_led_o,           // Indicator lit, high
   output logic      credit_latch_o,         // Latch state
   output logic      attract_o,              // Attract mode
   output logic      credit_expired_o        // Expiry flag
);
   // Synchronised inputs
   logic coin_active;    // Coin switch closed
   logic static_sync;    // Static seen
   logic two_games;      // two_games_per_coin setting
   logic coin_sw_sync;   // Synchronised switch level

   coin_sync u_sync_coin
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   (~coin_sw_n_i),
      .sync_o    (coin_sw_sync)
   );
   coin_sync u_sync_static
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   (static_detect_i),
      .sync_o    (static_sync)
   );
   coin_sync u_sync_sel
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   (games_per_coin_select_i),
      .sync_o    (two_games)
   );
   assign coin_active = coin_sw_sync;

   // State
   logic                                  debounce_reg;  // Coin flag
   logic [coin_credit_pkg::QUAL_W-1:0]    qual_cnt_reg;  // Delay timer
   logic                                  trig_reg;      // Accept done
   logic                                  accept_reg;    // Accept pulse
   logic                                  credit_reg;    // Credit latch
   logic                                  expired_reg;   // Expiry flag
   logic                                  games_reg;     // Games flag
   logic                                  attract_reg;   // Attract flag
   logic                                  attract_d_reg; // Edge detect
   logic                                  stop_d_reg;    // Edge detect
   logic                                  qual_done;     // Timer expired
   logic                                  game_over;     // Attract rise
   logic                                  expire_clr;    // Expiry clear
   logic                                  credit_clr;    // Latch clear

   // Debounce flag: set on closure, reset on rest position
   // Synchroniser does not filter bounce; flag follows the synchronised level
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         debounce_reg <= 1'b0;
      else
         debounce_reg <= coin_active;
   end

   // Qualification timer runs while the flag stays set
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || !debounce_reg)
         qual_cnt_reg <= '0;
      else if (!qual_done)
         qual_cnt_reg <= qual_cnt_reg + 1'b1;
   end
   assign qual_done = (qual_cnt_reg ==
      coin_credit_pkg::QUAL_W'(coin_credit_pkg::QUAL_CYCLES - 1));

   // One accept pulse per coin; trigger cleared on release
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || !debounce_reg)
      begin
         trig_reg   <= 1'b0;
         accept_reg <= 1'b0;
      end
      else
      begin
         accept_reg <= qual_done && !trig_reg;
         if (qual_done)
            trig_reg <= 1'b1;
      end
   end

   // Expiry clear: credit gone while in attract
   assign expire_clr = expired_reg && attract_reg;
   // A coin pulse clears the expiry flag in the same cycle, so the
   // expiry clear must not block the set that the coin itself makes
   assign credit_clr = static_sync
                       || (expire_clr && !accept_reg);

   // Credit latch; static clear wins over a coin set
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         credit_reg <= coin_credit_pkg::CREDIT_RST;
      else if (credit_clr)
         credit_reg <= 1'b0;
      else if (accept_reg)
         credit_reg <= 1'b1;
   end

   // Game over edge of the attract flag
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         attract_d_reg <= coin_credit_pkg::ATTRACT_RST;
         stop_d_reg    <= 1'b0;
      end
      else
      begin
         attract_d_reg <= attract_reg;
         stop_d_reg    <= game_stop_i;
      end
   end
   assign game_over = attract_reg && !attract_d_reg;

   // Games-per-coin flag; coin pulse loads !two_games, game over sets
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         games_reg <= coin_credit_pkg::GAMES_RST;
      else if (accept_reg)
         games_reg <= !two_games;
      else if (game_over)
         games_reg <= 1'b1;
   end

   // Credit-expired flag; preset while the latch is off
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         expired_reg <= coin_credit_pkg::EXPIRED_RST;
      else if (accept_reg && !credit_clr)
         expired_reg <= 1'b0;
      else if (!credit_reg)
         expired_reg <= 1'b1;
      else if (game_over)
         expired_reg <= games_reg;
   end

   // Attract flag; preset while latch off, stop sets, start clears
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         attract_reg <= coin_credit_pkg::ATTRACT_RST;
      else if (!credit_reg)
         attract_reg <= 1'b1;
      else if (game_stop_i && !stop_d_reg)
         attract_reg <= 1'b1;
      else if (start_accept_i && start_enable_o)
         attract_reg <= 1'b0;
   end

   // Outputs
   assign coin_accepted_n_o = !accept_reg;
   assign start_inhibit_o   = debounce_reg;
   assign start_enable_o    = credit_reg && !expired_reg
                              && !debounce_reg;
   assign credit_led_o      = credit_reg && !expired_reg;
   assign credit_latch_o    = credit_reg;
   assign attract_o         = attract_reg;
   assign credit_expired_o  = expired_reg;
endmodule : coin_credit_play_control
`default_nettype wire

// ===== tb/coin_credit_props.sv
// Port assertions for the coin credit control
`default_nettype none
module coin_credit_props
(
   // Clock, reset, game input
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic game_stop_i,
   // Outputs watched
   input wire logic coin_accepted_n_o,
   input wire logic start_inhibit_o,
   input wire logic start_enable_o,
   input wire logic credit_led_o,
   input wire logic credit_latch_o,
   input wire logic attract_o,
   input wire logic credit_expired_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // Accept strobe, low for one cycle
   sequence accept_s; !coin_accepted_n_o; endsequence
   chk_accept_single: assert property (accept_s |=> coin_accepted_n_o)
      else $error("accept strobe too long");
   chk_accept_cause: assert property (accept_s |-> $past(start_inhibit_o))
      else $error("accept without coin flag");
   chk_coin_grants: assert property (accept_s |=> !credit_expired_o)
      else $error("coin left credit expired");
   chk_inhibit_blocks: assert property (start_inhibit_o |-> !start_enable_o)
      else $error("start enabled during coin");
   chk_led_credit: assert property
      (credit_led_o == (credit_latch_o && !credit_expired_o))
      else $error("credit indicator wrong");
   chk_expiry_clears: assert property
      (credit_expired_o && attract_o && coin_accepted_n_o
       |=> !credit_latch_o)
      else $error("expired credit kept latch");
   chk_stop_attract: assert property
      ($rose(game_stop_i) |-> ##[1:2] attract_o)
      else $error("game over left play mode");
   // Reset value check must run while reset is high
   chk_reset_idle: assert property (disable iff (1'b0)
      reset_i |=> attract_o && credit_expired_o && !credit_latch_o)
      else $error("reset state wrong");
endmodule : coin_credit_props
bind coin_credit_play_control coin_credit_props i_props (.sys_clk_i,
   .reset_i, .game_stop_i, .coin_accepted_n_o, .start_inhibit_o,
   .start_enable_o, .credit_led_o, .credit_latch_o, .attract_o,
   .credit_expired_o);
`default_nettype wire

// ===== tb/cabinet_model.sv
// Cabinet side model: coin switch, static sensor, start, game over
`default_nettype none
module cabinet_model
(
   // Clock
   input  wire logic sys_clk_i,
   // Cabinet and game signals
   output logic      coin_sw_n_o,
   output logic      static_o,
   output logic      start_o,
   output logic      stop_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Switch rests open-high, all else idle
   initial
   begin
      coin_sw_n_o = 1'b1;
      static_o = 1'b0;
      start_o = 1'b0;
      stop_o = 1'b0;
   end
   // Coin closure of fixed length, caller is just past an edge
   task automatic coin(input int n);
      coin_sw_n_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      coin_sw_n_o <= 1'b1;
   endtask : coin
   // One-cycle start pulse
   task automatic press_start();
      start_o <= 1'b1;
      @(posedge sys_clk_i) start_o <= 1'b0;
   endtask : press_start
   // Level controls
   task automatic set_static(input logic v); static_o <= v; endtask : set_static
   task automatic set_stop(input logic v); stop_o <= v; endtask : set_stop
endmodule : cabinet_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the coin credit control
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, select, coin_n, stat, start, stop;
   logic accept_n, inhibit, enable, led, latch, attract, expired;
   int   num_errors, n_compared;
   // 20 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   coin_credit_play_control i_dut
   (
      .sys_clk_i(sys_clk), .reset_i(reset), .coin_sw_n_i(coin_n),
      .static_detect_i(stat), .games_per_coin_select_i(select),
      .start_accept_i(start), .game_stop_i(stop),
      .coin_accepted_n_o(accept_n), .start_inhibit_o(inhibit),
      .start_enable_o(enable), .credit_led_o(led),
      .credit_latch_o(latch), .attract_o(attract),
      .credit_expired_o(expired)
   );
   cabinet_model i_cab
   (
      .sys_clk_i(sys_clk), .coin_sw_n_o(coin_n), .static_o(stat),
      .start_o(start), .stop_o(stop)
   );
   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cycles
   task automatic check(input string name, input logic e, input logic g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %b seen %b", name, e, g);
      end
   endtask : check
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   // Full coin; accept lands about 200003 cycles into the closure
   task automatic insert_coin();
      fork
         i_cab.coin(200020);
         begin
            cycles(10);
            check("inhibit", 1'b1, inhibit);
            cycles(200005);
            check("latch", 1'b1, latch);
            check("enable in coin", 1'b0, enable);
         end
      join
      // Bounded wait for the switch release to reach the flag
      for (int i = 0; i < 10 && enable !== 1'b1; i++)
         cycles(1);
      check("enable", 1'b1, enable);
      check("led", 1'b1, led);
      check("expired", 1'b0, expired);
      if (enable !== 1'b1)
         final_report();
   endtask : insert_coin
   // Game over level held, then dropped
   task automatic game_over();
      i_cab.set_stop(1'b1);
      cycles(8);
      i_cab.set_stop(1'b0);
      cycles(2);
   endtask : game_over
   initial
   begin
      reset = 1'b1;
      select = 1'b0;
      num_errors = 0;
      n_compared = 0;
      cycles(10);
      reset <= 1'b0;
      cycles(3);
      check("attract", 1'b1, attract);
      check("enable", 1'b0, enable);
      i_cab.coin(100);
      cycles(10);
      check("short coin", 1'b0, latch);
      insert_coin();
      i_cab.press_start();
      cycles(3);
      check("play", 1'b0, attract);
      game_over();
      check("one game", 1'b0, enable);
      check("latch freed", 1'b0, latch);
      select <= 1'b1;
      insert_coin();
      i_cab.press_start();
      game_over();
      check("second game", 1'b1, enable);
      i_cab.press_start();
      game_over();
      check("two games", 1'b0, enable);
      insert_coin();
      i_cab.press_start();
      i_cab.set_static(1'b1);
      cycles(6);
      check("static", 1'b0, latch);
      check("static attract", 1'b1, attract);
      final_report();
   end
endmodule : tb
`default_nettype wire
